// ### src/adc_dc_consts.vh
// Function
// - shift output one bit per shift-clock fall
// - forward chain input after own result
// - no valid data until settling elapses
// - results in chain order, msb first
// - data ready low marks readable result
// - select high releases serial output
// - msb appears on select or ready fall
// - result is 24-bit twos complement
`ifndef ADC_DC_CONSTS_VH
`define ADC_DC_CONSTS_VH
`define ADC_DC_RES_W 24
`define ADC_DC_MSB 23
`define ADC_DC_CLK_NS 5
`define ADC_DC_MCLK_NS 1000
`define ADC_DC_DECIM 8
`define ADC_DC_SETTLE_MCLK 594
`define ADC_DC_UPDATE_MCLK 1
`define ADC_DC_CNT_W 20
`endif

// ### src/adc_dc_readout.v
`timescale 1ns/10ps
`include "adc_dc_consts.vh"
module adc_dc_readout #(
    parameter MCLK_CYC = `ADC_DC_MCLK_NS / `ADC_DC_CLK_NS,
    parameter SETTLE_CYC = `ADC_DC_SETTLE_MCLK * MCLK_CYC,
    parameter ODR_CYC = `ADC_DC_DECIM * MCLK_CYC,
    parameter UPDATE_CYC = `ADC_DC_UPDATE_MCLK * MCLK_CYC
)
(
    // clock and reset
    input wire clock_i,
    input wire rst_i,
    // converter core result
    input wire [`ADC_DC_MSB:0] conv_result_i,
    // pins from the host and the chain
    input wire shift_clk_i,
    input wire chip_select_n_i,
    input wire sync_powerdown_n_i,
    input wire chain_serial_in_i,
    // pins to the host
    output reg data_ready_n_o,
    output reg serial_result_out_o,
    output reg serial_result_oe_o
);

localparam ST_DOWN = 2'b00;
localparam ST_SETTLE = 2'b01;
localparam ST_UPDATE = 2'b10;
localparam ST_READ = 2'b11;

// counter loads, cut to the counter width on purpose
localparam [`ADC_DC_CNT_W-1:0] CNT_ONE = {{(`ADC_DC_CNT_W-1){1'b0}}, 1'b1};
localparam [`ADC_DC_CNT_W-1:0] SETTLE_LEN = SETTLE_CYC[`ADC_DC_CNT_W-1:0];
localparam [`ADC_DC_CNT_W-1:0] UPDATE_LEN = UPDATE_CYC[`ADC_DC_CNT_W-1:0];
localparam [`ADC_DC_CNT_W-1:0] READ_LEN = ODR_CYC[`ADC_DC_CNT_W-1:0] -
                                          UPDATE_CYC[`ADC_DC_CNT_W-1:0];

// a count of one or zero ends now, so a zero load cannot wrap
function cnt_done;
    input [`ADC_DC_CNT_W-1:0] cnt;
    begin
        cnt_done = (cnt <= CNT_ONE);
    end
endfunction

function [`ADC_DC_CNT_W-1:0] cnt_dec;
    input [`ADC_DC_CNT_W-1:0] cnt;
    begin
        cnt_dec = cnt - CNT_ONE;
    end
endfunction

// chain input enters behind the own lsb
function [`ADC_DC_MSB:0] shift_in;
    input [`ADC_DC_MSB:0] word;
    input bit_in;
    begin
        shift_in = {word[`ADC_DC_MSB-1:0], bit_in};
    end
endfunction

// three-stage sampling of the four pins; bit order sclk,cs,sync,sdi
reg [3:0] s1_r;
reg [3:0] s2_r;
reg [3:0] s3_r;
reg [3:0] pin_r;
reg [3:0] pin_prev_r;
reg [1:0] state_r;
reg [`ADC_DC_CNT_W-1:0] cnt_r;
reg [`ADC_DC_MSB:0] shift_r;
reg [1:0] state_nxt;
reg [`ADC_DC_CNT_W-1:0] cnt_nxt;
reg rdy_n_nxt;
reg [`ADC_DC_MSB:0] shift_nxt;
wire shift_en;
wire sclk_fall;
wire cs_n;
wire sync_n;
wire chain_serial_in;
integer i;

assign sclk_fall = pin_prev_r[0] & ~pin_r[0];
assign cs_n = pin_r[1];
assign sync_n = pin_r[2];
assign chain_serial_in = pin_r[3];
// pin filter limits the shift clock: half period of two clocks or more
assign shift_en = sclk_fall & ~cs_n;

always @(posedge clock_i)
begin
    s1_r <= {chain_serial_in_i, sync_powerdown_n_i, chip_select_n_i,
             shift_clk_i};
    s2_r <= s1_r;
    s3_r <= s2_r;
    pin_prev_r <= pin_r;
    if (rst_i)
    begin
        pin_r <= 4'h7;
        pin_prev_r <= 4'h7;
    end
    else
    begin
        // a pin changes only once stages two and three agree
        for (i = 0; i < 4; i = i + 1)
        begin
            if (s2_r[i] == s3_r[i])
                pin_r[i] <= s3_r[i];
        end
    end
end

// conversion timing: power-down, settling, then periodic results
always @*
begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rdy_n_nxt = data_ready_n_o;
    shift_nxt = shift_r;
    if (!sync_n)
    begin
        // sync low powers down; an unread word is simply lost
        state_nxt = ST_DOWN;
        cnt_nxt = {`ADC_DC_CNT_W{1'b0}};
        rdy_n_nxt = 1'b1;
    end
    else
    begin
        case (state_r)
            ST_DOWN:
            begin
                state_nxt = ST_SETTLE;
                cnt_nxt = SETTLE_LEN;
            end
            ST_SETTLE:
            begin
                if (cnt_done(cnt_r))
                begin
                    // first valid result only after settling
                    state_nxt = ST_READ;
                    cnt_nxt = READ_LEN;
                    rdy_n_nxt = 1'b0;
                    shift_nxt = conv_result_i;
                end
                else
                    cnt_nxt = cnt_dec(cnt_r);
            end
            ST_READ:
            begin
                if (cnt_done(cnt_r))
                begin
                    // output register updating, no read allowed
                    state_nxt = ST_UPDATE;
                    cnt_nxt = UPDATE_LEN;
                    rdy_n_nxt = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_dec(cnt_r);
                    // own bits leave first, then downstream data
                    if (shift_en)
                        shift_nxt = shift_in(shift_r, chain_serial_in);
                end
            end
            ST_UPDATE:
            begin
                if (cnt_done(cnt_r))
                begin
                    // a new word replaces whatever was left unshifted
                    state_nxt = ST_READ;
                    cnt_nxt = READ_LEN;
                    rdy_n_nxt = 1'b0;
                    shift_nxt = conv_result_i;
                end
                else
                    cnt_nxt = cnt_dec(cnt_r);
            end
            default:
                state_nxt = ST_DOWN;
        endcase
    end
end

always @(posedge clock_i)
begin
    if (rst_i)
    begin
        state_r <= ST_DOWN;
        cnt_r <= {`ADC_DC_CNT_W{1'b0}};
        data_ready_n_o <= 1'b1;
        shift_r <= {`ADC_DC_RES_W{1'b0}};
    end
    else
    begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        data_ready_n_o <= rdy_n_nxt;
        shift_r <= shift_nxt;
    end
end

// msb shows as soon as select is low and the result is loaded
always @(posedge clock_i)
begin
    if (rst_i)
    begin
        serial_result_out_o <= 1'b0;
        serial_result_oe_o <= 1'b0;
    end
    else
    begin
        serial_result_out_o <= shift_r[`ADC_DC_MSB];
        serial_result_oe_o <= ~cs_n;
    end
end

endmodule // adc_dc_readout

// ### verification/adc_dc_readout_chk.sv
`timescale 1ns/10ps
module adc_dc_readout_chk (
    input wire clock_i,
    input wire rst_i,
    input wire [23:0] conv_result_i,
    input wire shift_clk_i,
    input wire chip_select_n_i,
    input wire sync_powerdown_n_i,
    input wire chain_serial_in_i,
    input wire data_ready_n_o,
    input wire serial_result_out_o,
    input wire serial_result_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_OE_OFF: assert property (chip_select_n_i [*8] |-> !serial_result_oe_o)
        else $error("oe high");
    AST_OE_ON: assert property (!chip_select_n_i [*8] |-> serial_result_oe_o)
        else $error("oe low");
    AST_PD: assert property (!sync_powerdown_n_i [*8] |-> data_ready_n_o)
        else $error("rdy in pd");
    AST_SETTLE: assert property ($rose(sync_powerdown_n_i) |-> data_ready_n_o [*8])
        else $error("early rdy");
    AST_LOAD: assert property ($fell(data_ready_n_o) |=>
        serial_result_out_o == $past(conv_result_i[23]))
        else $error("msb");
    AST_LOW: assert property ($fell(data_ready_n_o) |=> !data_ready_n_o [*8])
        else $error("short rdy");
    AST_IDLE: assert property (data_ready_n_o && $past(data_ready_n_o) |->
        $stable(serial_result_out_o))
        else $error("shift idle");
    AST_SCLK: assert property (shift_clk_i [*8] |->
        $stable(serial_result_out_o) || $past(data_ready_n_o, 2))
        else $error("shift no edge");
    cover property ($fell(data_ready_n_o));
    cover property ($fell(shift_clk_i) && !data_ready_n_o);
    cover property ($rose(serial_result_oe_o));
endmodule // adc_dc_readout_chk
bind adc_dc_readout adc_dc_readout_chk adc_dc_readout_chk_i (.*);

// ### verification/adc_dc_host.sv
`timescale 1ns/10ps
module adc_dc_host (
    input wire data_ready_n_i,
    input wire sdo_i,
    output reg sclk_o,
    output reg [47:0] data_o
);
    integer i;
    initial sclk_o = 1'b1;
    always @(negedge data_ready_n_i)
    begin
        #400;
        for (i = 0; i < 48; i = i + 1)
        begin
            data_o = {data_o[46:0], sdo_i};
            sclk_o = 1'b0;
            #80 sclk_o = 1'b1;
            #80;
        end
    end
endmodule // adc_dc_host

// ### verification/adc_dc_readout_bench.sv
`timescale 1ns/10ps
module adc_dc_readout_bench;
    reg clock_i = 0;
    reg rst_i = 1;
    reg cs_n = 0;
    reg sync_n = 1;
    reg [23:0] res_a = 24'h8a5c31;
    reg [23:0] res_b = 24'h35f0e7;
    reg last_sdi = 1'b0;
    wire sclk, rdy_n, rdy_b_n, serial_result_out, sdo_b, oe, oe_b;
    wire [47:0] got;
    integer n_errors = 0;
    integer tests_run = 0;
    always #2.5 clock_i = ~clock_i;
    adc_dc_readout #(.SETTLE_CYC(200), .ODR_CYC(4000))
    adc_dc_readout_i (.clock_i(clock_i), .rst_i(rst_i),
        .conv_result_i(res_a), .shift_clk_i(sclk),
        .chip_select_n_i(cs_n), .sync_powerdown_n_i(sync_n),
        .chain_serial_in_i(sdo_b), .data_ready_n_o(rdy_n),
        .serial_result_out_o(serial_result_out), .serial_result_oe_o(oe));
    adc_dc_readout #(.SETTLE_CYC(200), .ODR_CYC(4000))
    adc_dc_readout_b_i (.clock_i(clock_i), .rst_i(rst_i),
        .conv_result_i(res_b), .shift_clk_i(sclk),
        .chip_select_n_i(cs_n), .sync_powerdown_n_i(sync_n),
        .chain_serial_in_i(last_sdi), .data_ready_n_o(rdy_b_n),
        .serial_result_out_o(sdo_b), .serial_result_oe_o(oe_b));
    adc_dc_host adc_dc_host_i (.data_ready_n_i(rdy_n), .sdo_i(serial_result_out),
        .sclk_o(sclk), .data_o(got));
    task chk(input [8*6-1:0] name, input [47:0] exp, input [47:0] seen);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    end
    endtask
    task finish_test;
    begin
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task step(input integer n);
    begin
        repeat (n) @(posedge clock_i);
        #1;
    end
    endtask
    task test_sync;
    begin
        sync_n = 0;
        step(20);
        chk("pdrdy", 48'h1, {47'h0, rdy_n});
        sync_n = 1;
        step(150);
        chk("settle", 48'h1, {47'h0, rdy_n});
    end
    endtask
    task test_chain;
    begin
        @(negedge rdy_n);
        @(posedge rdy_n);
        chk("chain", 48'h8a5c3135f0e7, got);
        chk("rdyb", 48'h1, {47'h0, rdy_b_n});
    end
    endtask
    task test_cs;
    begin
        cs_n = 1;
        step(10);
        chk("oeoff", 48'h0, {47'h0, oe});
        chk("oeboff", 48'h0, {47'h0, oe_b});
        cs_n = 0;
        step(10);
        chk("oeon", 48'h1, {47'h0, oe});
        chk("oebon", 48'h1, {47'h0, oe_b});
    end
    endtask
    initial
    begin
        step(12);
        rst_i = 0;
        test_sync;
        test_chain;
        test_cs;
        finish_test;
    end
    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule // adc_dc_readout_bench
